// ---- hw/axdp_port.sv ----
/*
 * One downstream AXI port of the interconnect: address, write-data and
 * response channels toward one attached slave, plus a small command port.
 * Assumes upstream logic already decoded and picked this port.
 */
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "axdp_params.svh"
module axdp_port #(
  parameter axdp_pkg::axdp_proto_e PROTO    = axdp_pkg::AXDP_AXI4,
  parameter bit                    CASCADED = 1'b0,
  parameter int                    PORT_IDX = 0,
  parameter int UW  = CASCADED ? `AXDP_CASC_USER_W : `AXDP_USER_W,
  parameter int LW  = (PROTO == axdp_pkg::AXDP_AXI3) ? `AXDP_LEN3_W : `AXDP_LEN4_W,
  parameter int KW  = (PROTO == axdp_pkg::AXDP_AXI3) ? `AXDP_LOCK3_W : `AXDP_LOCK4_W
) (
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // command port
  input  wire logic [3:0]                  reg_addr_i,
  input  wire logic [31:0]                 reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [31:0]                 reg_rdata_o,
  // upstream address, write-data and response channels (shared fields per direction)
  input  wire logic [`AXDP_ID_W-1:0]       up_awid_i,
  input  wire logic [`AXDP_UP_ADDR_W-1:0]  up_awaddr_i,
  input  wire logic [7:0]                  up_awlen_i,
  input  wire logic [`AXDP_SIZE_W-1:0]     up_awsize_i,
  input  wire logic                        up_awlock_i,
  input  wire logic [`AXDP_CACHE_W-1:0]    up_awcache_i,
  input  wire logic [`AXDP_PROT_W-1:0]     up_awprot_i,
  input  wire logic [`AXDP_QOS_W-1:0]      up_awqos_i,
  input  wire logic [UW-1:0]               up_awuser_i,
  input  wire logic                        up_awvalid_i,
  output logic                             up_awready_o,
  input  wire logic [`AXDP_DATA_W-1:0]     up_wdata_i,
  input  wire logic [`AXDP_DATA_W/8-1:0]   up_wstrb_i,
  input  wire logic                        up_wlast_i,
  input  wire logic [UW-1:0]               up_wuser_i,
  input  wire logic                        up_wvalid_i,
  output logic                             up_wready_o,
  output logic      [`AXDP_RESP_W-1:0]     up_bresp_o,
  output logic      [UW-1:0]               up_buser_o,
  output logic      [`AXDP_ID_W-1:0]       up_bid_o,
  output logic                             up_bvalid_o,
  input  wire logic                        up_bready_i,
  input  wire logic [`AXDP_ID_W-1:0]       up_arid_i,
  input  wire logic [`AXDP_UP_ADDR_W-1:0]  up_araddr_i,
  input  wire logic [7:0]                  up_arlen_i,
  input  wire logic [`AXDP_SIZE_W-1:0]     up_arsize_i,
  input  wire logic                        up_arlock_i,
  input  wire logic [`AXDP_CACHE_W-1:0]    up_arcache_i,
  input  wire logic [`AXDP_PROT_W-1:0]     up_arprot_i,
  input  wire logic [`AXDP_QOS_W-1:0]      up_arqos_i,
  input  wire logic [UW-1:0]               up_aruser_i,
  input  wire logic                        up_arvalid_i,
  output logic                             up_arready_o,
  output logic      [`AXDP_DATA_W-1:0]     up_rdata_o,
  output logic      [`AXDP_RESP_W-1:0]     up_rresp_o,
  output logic                             up_rlast_o,
  output logic      [UW-1:0]               up_ruser_o,
  output logic      [`AXDP_ID_W-1:0]       up_rid_o,
  output logic                             up_rvalid_o,
  input  wire logic                        up_rready_i,
  // downstream_port toward the slave
  output logic      [`AXDP_ID_W-1:0]       awid_o,
  output logic      [`AXDP_DN_ADDR_W-1:0]  awaddr_o,
  output logic      [LW-1:0]               awlen_o,
  output logic      [`AXDP_SIZE_W-1:0]     awsize_o,
  output logic      [1:0]                  awburst_o,
  output logic      [KW-1:0]               awlock_o,
  output logic      [`AXDP_CACHE_W-1:0]    awcache_o,
  output logic      [`AXDP_PROT_W-1:0]     awprot_o,
  output logic      [`AXDP_QOS_W-1:0]      awqos_o,
  output logic      [UW-1:0]               awuser_o,
  output logic                             awvalid_o,
  input  wire logic                        awready_i,
  output logic      [`AXDP_ID_W-1:0]       wid_o,
  output logic      [`AXDP_DATA_W-1:0]     wdata_o,
  output logic      [`AXDP_DATA_W/8-1:0]   wstrb_o,
  output logic                             wlast_o,
  output logic      [UW-1:0]               wuser_o,
  output logic                             wvalid_o,
  input  wire logic                        wready_i,
  input  wire logic [`AXDP_ID_W-1:0]       bid_i,
  input  wire logic [`AXDP_RESP_W-1:0]     bresp_i,
  input  wire logic [UW-1:0]               buser_i,
  input  wire logic                        bvalid_i,
  output logic                             bready_o,
  output logic      [`AXDP_ID_W-1:0]       arid_o,
  output logic      [`AXDP_DN_ADDR_W-1:0]  araddr_o,
  output logic      [LW-1:0]               arlen_o,
  output logic      [`AXDP_SIZE_W-1:0]     arsize_o,
  output logic      [1:0]                  arburst_o,
  output logic      [KW-1:0]               arlock_o,
  output logic      [`AXDP_CACHE_W-1:0]    arcache_o,
  output logic      [`AXDP_PROT_W-1:0]     arprot_o,
  output logic      [`AXDP_QOS_W-1:0]      arqos_o,
  output logic      [UW-1:0]               aruser_o,
  output logic                             arvalid_o,
  input  wire logic                        arready_i,
  input  wire logic [`AXDP_ID_W-1:0]       rid_i,
  input  wire logic [`AXDP_DATA_W-1:0]     rdata_i,
  input  wire logic [`AXDP_RESP_W-1:0]     rresp_i,
  input  wire logic                        rlast_i,
  input  wire logic [UW-1:0]               ruser_i,
  input  wire logic                        rvalid_i,
  output logic                             rready_o
);
  localparam bit LITE = (PROTO == axdp_pkg::AXDP_LITE);
  localparam bit AXI3 = (PROTO == axdp_pkg::AXDP_AXI3);
  localparam int WW   = `AXDP_DATA_W + `AXDP_DATA_W/8 + 1 + UW;

  // ***********************************************************
  // command port
  // ***********************************************************
  logic [31:0] ctrl, next_ctrl, beats, next_beats;
  logic [31:0] next_rdata, rdata_q;
  logic        en;
  assign en = ctrl[`AXDP_CTRL_EN_BIT];

  always_comb begin
    next_ctrl  = ctrl;
    next_rdata = 32'h0000_0000;
    if (reg_wr_i && reg_addr_i == `AXDP_REG_CTRL) begin
      next_ctrl = {31'h0, reg_wdata_i[`AXDP_CTRL_EN_BIT]};
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `AXDP_REG_CTRL:   next_rdata = ctrl;
        `AXDP_REG_STATUS: next_rdata = {26'h0, PORT_IDX[3:0], awvalid_o, arvalid_o};
        `AXDP_REG_COUNT:  next_rdata = beats;
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************************
  // address channels: one register stage each
  // ***********************************************************
  logic aw_full, next_aw_full, ar_full, next_ar_full;
  logic [`AXDP_DN_ADDR_W-1:0] next_awaddr, next_araddr;
  assign up_awready_o = en && (!aw_full || awready_i);
  assign up_arready_o = en && (!ar_full || arready_i);
  assign awvalid_o    = aw_full;
  assign arvalid_o    = ar_full;
  assign awburst_o    = `AXDP_BURST_INCR;
  assign arburst_o    = `AXDP_BURST_INCR;

  always_comb begin
    // payload held until the slave takes it
    next_aw_full = aw_full && !awready_i;
    next_ar_full = ar_full && !arready_i;
    if (up_awvalid_i && up_awready_o) next_aw_full = 1'b1;
    if (up_arvalid_i && up_arready_o) next_ar_full = 1'b1;
    next_awaddr = up_awaddr_i[`AXDP_DN_ADDR_W-1:0];
    next_araddr = up_araddr_i[`AXDP_DN_ADDR_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl    <= `AXDP_CTRL_RST;
      rdata_q <= 32'h0000_0000;
      aw_full <= 1'b0;
      ar_full <= 1'b0;
      beats   <= 32'h0000_0000;
      awid_o    <= '0;
      awaddr_o  <= '0;
      awlen_o   <= '0;
      awsize_o  <= '0;
      awlock_o  <= '0;
      awcache_o <= '0;
      awprot_o  <= '0;
      awqos_o   <= '0;
      awuser_o  <= '0;
      arid_o    <= '0;
      araddr_o  <= '0;
      arlen_o   <= '0;
      arsize_o  <= '0;
      arlock_o  <= '0;
      arcache_o <= '0;
      arprot_o  <= '0;
      arqos_o   <= '0;
      aruser_o  <= '0;
    end else begin
      ctrl    <= next_ctrl;
      rdata_q <= next_rdata;
      aw_full <= next_aw_full;
      ar_full <= next_ar_full;
      beats   <= next_beats;
      if (up_awvalid_i && up_awready_o) begin
        awid_o    <= CASCADED ? up_awid_i : '0;
        awaddr_o  <= next_awaddr;
        awlen_o   <= LW'(up_awlen_i);
        awsize_o  <= up_awsize_i;
        awlock_o  <= KW'(up_awlock_i);
        awcache_o <= up_awcache_i;
        awprot_o  <= up_awprot_i;
        awqos_o   <= up_awqos_i;
        awuser_o  <= up_awuser_i;
      end
      if (up_arvalid_i && up_arready_o) begin
        arid_o    <= CASCADED ? up_arid_i : '0;
        araddr_o  <= next_araddr;
        arlen_o   <= LW'(up_arlen_i);
        arsize_o  <= up_arsize_i;
        arlock_o  <= KW'(up_arlock_i);
        arcache_o <= up_arcache_i;
        arprot_o  <= up_arprot_i;
        arqos_o   <= up_arqos_i;
        aruser_o  <= up_aruser_i;
      end
    end
  end
  assign reg_rdata_o = rdata_q;

  // ***********************************************************
  // write data through the FIFO
  // ***********************************************************
  logic [WW-1:0] w_out;
  logic          w_in_ready;
  assign up_wready_o = en && w_in_ready;
  axdp_fifo #(.WIDTH(WW), .DEPTH(`AXDP_FIFO_DEPTH)) u_wfifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   ({up_wdata_i, up_wstrb_i, up_wlast_i, up_wuser_i}),
    .in_valid_i  (up_wvalid_i && en),
    .in_ready_o  (w_in_ready),
    .out_data_o  (w_out),
    .out_valid_o (wvalid_o),
    .out_ready_i (wready_i)
  );
  assign {wdata_o, wstrb_o, wlast_o, wuser_o} = w_out;
  // data order is kept, so only AXI3 cascades see a write id
  assign wid_o = (AXI3 && CASCADED) ? awid_o : '0;

  always_comb begin
    next_beats = beats;
    if (wvalid_o && wready_i) next_beats = beats + 32'h1;
  end

  // ***********************************************************
  // responses: lite ports drop ids, last and user
  // ***********************************************************
  assign bready_o    = up_bready_i;
  assign up_bvalid_o = bvalid_i;
  assign up_bresp_o  = bresp_i;
  assign up_bid_o    = LITE ? '0 : bid_i;
  assign up_buser_o  = LITE ? '0 : buser_i;
  assign rready_o    = up_rready_i;
  assign up_rvalid_o = rvalid_i;
  assign up_rdata_o  = rdata_i;
  assign up_rresp_o  = rresp_i;
  assign up_rlast_o  = LITE ? 1'b1 : rlast_i;
  assign up_rid_o    = LITE ? '0 : rid_i;
  assign up_ruser_o  = LITE ? '0 : ruser_i;

  // ***********************************************************
  // checks
  // ***********************************************************
  a_aw_burst_incr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    awvalid_o |-> awburst_o == `AXDP_BURST_INCR) else $error("aw burst not incr");
  a_aw_hold_stable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    awvalid_o && !awready_i |=> awvalid_o && $stable(awaddr_o))
    else $error("aw dropped before ready");
  a_ar_hold_stable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    arvalid_o && !arready_i |=> arvalid_o && $stable(araddr_o))
    else $error("ar dropped before ready");
  a_aw_addr_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_awvalid_i && up_awready_o |=> awaddr_o == $past(next_awaddr))
    else $error("aw address not forwarded");
  a_ar_qos_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_arvalid_i && up_arready_o |=> arqos_o == $past(up_arqos_i))
    else $error("ar qos not forwarded");
  a_aw_lock_legal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    awvalid_o |-> awlock_o <= KW'(1)) else $error("aw lock out of range");
  a_ar_id_endpoint: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !CASCADED && arvalid_o |-> arid_o == '0) else $error("id sent to endpoint");
  a_w_hold_valid: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wvalid_o && !wready_i |=> wvalid_o && $stable(wdata_o))
    else $error("w dropped before ready");
  a_ar_addr_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_arvalid_i && up_arready_o |=> araddr_o == $past(up_araddr_i[`AXDP_DN_ADDR_W-1:0]))
    else $error("ar address not forwarded");
  a_aw_qos_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_awvalid_i && up_awready_o |=> awqos_o == $past(up_awqos_i))
    else $error("aw qos not forwarded");
  a_aw_len_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_awvalid_i && up_awready_o |=> awlen_o == LW'($past(up_awlen_i)))
    else $error("aw length not forwarded");
  a_ar_size_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_arvalid_i && up_arready_o |=> arsize_o == $past(up_arsize_i))
    else $error("ar size not forwarded");
  a_aw_prot_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_awvalid_i && up_awready_o |=> awprot_o == $past(up_awprot_i))
    else $error("aw protection not forwarded");
  a_aw_user_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_awvalid_i && up_awready_o |=> awuser_o == $past(up_awuser_i))
    else $error("aw user not forwarded");
  a_ar_user_fwd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    up_arvalid_i && up_arready_o |=> aruser_o == $past(up_aruser_i))
    else $error("ar user not forwarded");
endmodule // axdp_port

// ---- pkg/axdp_params.svh ----
/*
 * Constants for the downstream port block: field widths, encodings, defaults
 * and the port register-map offsets. Assumes it is included by bare name.
 */
`ifndef AXDP_PARAMS_SVH
`define AXDP_PARAMS_SVH
`define AXDP_NUM_PORTS    2
`define AXDP_DATA_W       32
`define AXDP_UP_ADDR_W    64
`define AXDP_DN_ADDR_W    32
`define AXDP_ID_W         4
`define AXDP_USER_W       8
`define AXDP_CASC_USER_W  1024
`define AXDP_QOS_W        4
`define AXDP_SIZE_W       3
`define AXDP_PROT_W       3
`define AXDP_CACHE_W      4
`define AXDP_RESP_W       2
`define AXDP_LEN4_W       8
`define AXDP_LEN3_W       4
`define AXDP_LOCK4_W      1
`define AXDP_LOCK3_W      2
`define AXDP_BURST_INCR   2'h1
`define AXDP_RESP_OKAY    2'h0
`define AXDP_FIFO_DEPTH   16
// command port offsets
`define AXDP_REG_CTRL     4'h0
`define AXDP_REG_STATUS   4'h1
`define AXDP_REG_COUNT    4'h2
`define AXDP_CTRL_EN_BIT  0
`define AXDP_CTRL_RST     32'h0000_0001
`endif

// ---- pkg/axdp_pkg.sv ----
/*
 * Types for the downstream port block. Assumes axdp_params.svh is compiled alongside.
 */
package axdp_pkg;
  typedef enum logic [1:0] {
    AXDP_AXI4  = 2'b00,
    AXDP_AXI3  = 2'b01,
    AXDP_LITE  = 2'b10
  } axdp_proto_e;
  typedef enum logic [0:0] {
    AXDP_LOCK_NORMAL    = 1'b0,
    AXDP_LOCK_EXCLUSIVE = 1'b1
  } axdp_lock_e;
endpackage

// ---- hw/axdp_fifo.sv ----
/*
 * Parameterised valid/ready FIFO used on the downstream write-data path.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module axdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // axdp_fifo

// ---- tb/axdp_slave_model.sv ----
/*
 * Behavioural slave standing on the downstream port: random ready, one write
 * response per completed burst, read beats served in order.
 * Assumes the same clock and synchronous active-low reset as the port.
 */
`timescale 1ns/1ps
module axdp_slave_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        hold_w,
  input  wire logic [31:0] awaddr_o,
  input  wire logic        awvalid_o,
  output logic             awready_i,
  input  wire logic        wlast_o,
  input  wire logic        wvalid_o,
  output logic             wready_i,
  output logic      [1:0]  bresp_i,
  output logic             bvalid_i,
  input  wire logic        bready_o,
  input  wire logic [31:0] araddr_o,
  input  wire logic [7:0]  arlen_o,
  input  wire logic        arvalid_o,
  output logic             arready_i,
  output logic      [31:0] rdata_i,
  output logic             rlast_i,
  output logic             rvalid_i,
  input  wire logic        rready_o
);
  logic [31:0] aw_q[$];
  logic [39:0] ar_q[$];
  logic [39:0] cur;
  logic [31:0] a;
  int          wdone;
  int          beat;
  bit          busy;
  int          seed = 32'h3d38;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      {awready_i, wready_i, bvalid_i, arready_i, rvalid_i, rlast_i, bresp_i, rdata_i} <= '0;
      aw_q.delete();
      ar_q.delete();
      wdone = 0;
      busy = 0;
    end else begin
      awready_i <= 1'($random(seed));
      arready_i <= 1'($random(seed));
      wready_i <= !hold_w && 1'($random(seed));
      if (awvalid_o && awready_i) aw_q.push_back(awaddr_o);
      if (wvalid_o && wready_i && wlast_o) wdone++;
      if (arvalid_o && arready_i) ar_q.push_back({arlen_o, araddr_o});
      // released bresp and rdata lines invert so a stale value never looks valid
      if (bvalid_i && bready_o) begin
        bvalid_i <= 1'b0;
        bresp_i <= ~bresp_i;
      end else if (!bvalid_i && wdone > 0 && aw_q.size() > 0) begin
        a = aw_q.pop_front();
        bvalid_i <= 1'b1;
        bresp_i <= {a[2], 1'b0};
        wdone--;
      end
      if (rvalid_i && rready_o) begin
        if (rlast_i) busy = 0;
        else beat++;
      end
      if (!rvalid_i || rready_o) begin
        if (!busy && ar_q.size() > 0) begin
          cur = ar_q.pop_front();
          busy = 1;
          beat = 0;
        end
        if (busy && 1'($random(seed))) begin
          rvalid_i <= 1'b1;
          rdata_i <= cur[31:0] ^ beat;
          rlast_i <= (beat == cur[39:32]);
        end else begin
          rvalid_i <= 1'b0;
          rdata_i <= ~rdata_i;
        end
      end
    end
  end
endmodule // axdp_slave_model

// ---- tb/axdp_port_tb.sv ----
/*
 * Self-checking bench for one downstream port: queues of expected beats
 * compared at every downstream AW, AR and W and upstream R and B handshake. Assumes an AXI4 endpoint, 32-bit data.
 */
`timescale 1ns/1ps
`include "axdp_params.svh"
module axdp_port_tb;
  logic        clk_i, reset_n_i, reg_wr_i, reg_rd_i, hold_w;
  logic        up_awlock_i, up_awvalid_i, up_awready_o, up_wlast_i, up_wvalid_i, up_wready_o;
  logic        up_bvalid_o, up_bready_i, up_arlock_i, up_arvalid_i, up_arready_o, up_rlast_o;
  logic        up_rvalid_o, up_rready_i, awlock_o, awvalid_o, awready_i, wlast_o, wvalid_o;
  logic        wready_i, bvalid_i, bready_o, arlock_o, arvalid_o, arready_i, rlast_i, rvalid_i;
  logic        rready_o;
  logic [1:0]  up_bresp_o, up_rresp_o, awburst_o, bresp_i, arburst_o, rresp_i;
  logic [2:0]  up_awsize_i, up_awprot_i, up_arsize_i, up_arprot_i, awsize_o, awprot_o;
  logic [2:0]  arsize_o, arprot_o;
  logic [3:0]  reg_addr_i, up_awid_i, up_awcache_i, up_awqos_i, up_bid_o, up_arid_i;
  logic [3:0]  up_arcache_i, up_arqos_i, up_rid_o, awid_o, awcache_o, awqos_o, wid_o;
  logic [3:0]  wstrb_o, up_wstrb_i, bid_i, arid_o, arcache_o, arqos_o, rid_i;
  logic [7:0]  up_awlen_i, up_awuser_i, up_wuser_i, up_buser_o, up_arlen_i, up_aruser_i;
  logic [7:0]  up_ruser_o, awlen_o, awuser_o, wuser_o, buser_i, arlen_o, aruser_o, ruser_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, up_wdata_i, up_rdata_o, awaddr_o, wdata_o, araddr_o;
  logic [31:0] rdata_i;
  logic [63:0] up_awaddr_i, up_araddr_i;
  logic [127:0] aw_q[$], ar_q[$], w_q[$], r_q[$], b_q[$];
  int          bad_count, total_checks, cyc, wbeats, up_wacc, acc0;
  int          seed = 32'h3d38;
  logic [23:0] resp_tag;
  // ids and user come back unchanged on an AXI4 port; read resp sits at its idle default
  assign {bid_i, rid_i, buser_i, ruser_i} = resp_tag;
  assign rresp_i = 2'h0;
  axdp_port #(.PORT_IDX(5)) dut_u (.*);
  axdp_slave_model slv_u (.*);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic chk(input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge clk_i) reg_rd_i <= 1'b0;
    #1 chk(e, reg_rdata_o);
  endtask
  task automatic send_aw(input logic [63:0] a, input logic [7:0] len);
    logic [26:0] f;
    f = 27'($random(seed));
    aw_q.push_back({a[31:0], len, f[26:4]});
    b_q.push_back({a[2], 1'b0});
    @(posedge clk_i) {up_awaddr_i, up_awlen_i, up_awsize_i, up_awlock_i, up_awcache_i,
      up_awprot_i, up_awqos_i, up_awuser_i, up_awid_i, up_awvalid_i} <= {a, len, f, 1'b1};
    do @(posedge clk_i); while (up_awready_o !== 1'b1);
    up_awvalid_i <= 1'b0;
  endtask
  task automatic send_ar(input logic [63:0] a, input logic [7:0] len);
    logic [26:0] f;
    f = 27'($random(seed));
    ar_q.push_back({a[31:0], len, f[26:4]});
    for (int b = 0; b <= len; b++) r_q.push_back({a[31:0] ^ b, 2'h0, b == len});
    @(posedge clk_i) {up_araddr_i, up_arlen_i, up_arsize_i, up_arlock_i, up_arcache_i,
      up_arprot_i, up_arqos_i, up_aruser_i, up_arid_i, up_arvalid_i} <= {a, len, f, 1'b1};
    do @(posedge clk_i); while (up_arready_o !== 1'b1);
    up_arvalid_i <= 1'b0;
  endtask
  task automatic send_w(input int n);
    logic [43:0] v;
    @(posedge clk_i);
    for (int b = 0; b < n; b++) begin
      v = 44'({$random(seed), $random(seed)});
      w_q.push_back({v[43:8], b == n - 1, v[7:0]});
      {up_wdata_i, up_wstrb_i, up_wlast_i, up_wuser_i, up_wvalid_i} <= {v[43:8], b == n - 1,
        v[7:0], 1'b1};
      do @(posedge clk_i); while (up_wready_o !== 1'b1);
    end
    up_wvalid_i <= 1'b0;
  endtask
  // ***************************************************
  // monitor and timeout
  // ***************************************************
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
    if (reset_n_i) begin
      if (awvalid_o && awready_i) begin
        chk(aw_q.pop_front(), {awaddr_o, awlen_o, awsize_o, awlock_o, awcache_o, awprot_o,
          awqos_o, awuser_o});
        chk({`AXDP_BURST_INCR, 4'h0}, {awburst_o, awid_o});
      end
      if (arvalid_o && arready_i) begin
        chk(ar_q.pop_front(), {araddr_o, arlen_o, arsize_o, arlock_o, arcache_o, arprot_o,
          arqos_o, aruser_o});
        chk({`AXDP_BURST_INCR, 4'h0}, {arburst_o, arid_o});
      end
      if (wvalid_o && wready_i) begin
        chk(w_q.pop_front(), {wid_o, wdata_o, wstrb_o, wlast_o,
          wuser_o});
        wbeats++;
      end
      if (up_wvalid_i && up_wready_o) up_wacc++;
      if (up_rvalid_o && up_rready_i) begin
        chk(r_q.pop_front(), {up_rdata_o, up_rresp_o, up_rlast_o});
        chk({resp_tag[19:16], resp_tag[7:0]}, {up_rid_o, up_ruser_o});
      end
      if (up_bvalid_o && up_bready_i) begin
        chk(b_q.pop_front(), up_bresp_o);
        chk({resp_tag[23:20], resp_tag[15:8]}, {up_bid_o, up_buser_o});
      end
      up_bready_i <= 1'($random(seed));
      up_rready_i <= 1'($random(seed));
    end
  end
  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, hold_w, up_awvalid_i, up_wvalid_i, up_arvalid_i} = '0;
    {up_bready_i, up_rready_i, reg_addr_i, reg_wdata_i, up_awid_i, up_arid_i} = '0;
    {up_awaddr_i, up_awlen_i, up_awsize_i, up_awlock_i, up_awcache_i, up_awprot_i} = '0;
    {up_awqos_i, up_awuser_i, up_araddr_i, up_arlen_i, up_arsize_i, up_arlock_i} = '0;
    {up_arcache_i, up_arprot_i, up_arqos_i, up_aruser_i, up_wdata_i, up_wstrb_i} = '0;
    {up_wlast_i, up_wuser_i} = '0;
    resp_tag = 24'($random(seed));
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reg_rd(`AXDP_REG_CTRL, `AXDP_CTRL_RST);
    reg_wr(4'hF, $random(seed));
    reg_rd(4'hF, 32'h0);
    reg_rd(`AXDP_REG_STATUS, 32'h0000_0014);
    $display("registers done");
    fork
      for (int i = 0; i < 40; i++) begin
        automatic logic [7:0] l = 8'($random(seed) & 7);
        send_aw({$random(seed), $random(seed)}, l);
        send_w(l + 1);
      end
      for (int i = 0; i < 40; i++) send_ar({$random(seed), $random(seed)}, 8'($random(seed) & 7));
    join
    send_aw(64'hFFFF_FFFF_FFFF_FFFC, 8'hFF);
    send_w(256);
    repeat (100) @(posedge clk_i);
    $display("traffic done");
    // slave stalls W so the fifo must fill and refuse
    acc0 = up_wacc;
    hold_w <= 1'b1;
    send_aw(64'h40, 8'd19);
    fork
      send_w(20);
    join_none
    repeat (60) @(posedge clk_i);
    chk(`AXDP_FIFO_DEPTH, up_wacc - acc0);
    chk(1'b0, up_wready_o);
    hold_w <= 1'b0;
    wait fork;
    $display("fifo done");
    reg_wr(`AXDP_REG_CTRL, 32'h0);
    fork
      send_ar(64'h1234_5678, 8'h2);
    join_none
    repeat (8) @(posedge clk_i);
    chk(2'b00, {up_arready_o, arvalid_o});
    reg_wr(`AXDP_REG_CTRL, `AXDP_CTRL_RST);
    wait fork;
    repeat (300) @(posedge clk_i);
    reg_rd(`AXDP_REG_COUNT, wbeats);
    chk(0, aw_q.size() + ar_q.size() + w_q.size() + r_q.size() + b_q.size());
    $display("disable and drain done");
    wrap_up();
  end
endmodule // axdp_port_tb
